// [design/sensor_end.sv]
// Purpose: sensor side of the serial port with angle conditioning
// Assumes: link pins asynchronous to aclk, sclk well below aclk/4
// Notes: register writes commit only after the nonvolatile wait
`timescale 1ns/1ps
module sensor_end #(
  parameter int NVM_WAIT_CYC = angle_spi_pkg::NVM_WAIT_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  angle_spi_if.sensor spi,
  // front end
  input wire logic phase_zero,
  input wire logic [angle_spi_pkg::FIELD_W-1:0] field_strength,
  // conditioned outputs
  output logic field_low_flag,
  output logic field_high_flag,
  output logic [angle_spi_pkg::ANGLE_BITS-1:0] angle_out
);
  import angle_spi_pkg::*;
  localparam int WC_W = $clog2(NVM_WAIT_CYC + 1);

  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic mosi_s1, mosi_s2;
  logic ph_s1, ph_s2, ph_s3;
  logic rise, fall, cs_fall, cs_rise;
  logic mode3_q, mode3_d;
  logic first_q, first_d;
  logic [15:0] tx_q, tx_d;
  logic [15:0] rx_q, rx_d;
  logic [4:0] cnt_q, cnt_d;
  logic oe_n_q, oe_n_d;
  logic reply_q, reply_d;
  logic [4:0] raddr_q, raddr_d;
  logic busy_q, busy_d;
  logic [WC_W-1:0] wcnt_q, wcnt_d;
  logic [4:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [15:0] zero_q, zero_d;
  logic [7:0] thr_q, thr_d;
  logic dir_q, dir_d;
  logic [6:0] ref_q, ref_d;
  logic [15:0] acc_q, acc_d;
  logic [15:0] samp_q, samp_d;
  logic sv_q, sv_d;
  logic [15:0] filt;
  logic [15:0] turned;
  logic low_d, high_d;
  logic [ANGLE_BITS-1:0] ang_d;

  // register readback decode
  function automatic logic [7:0] reg_value(
    input logic [4:0] a,
    input logic [15:0] z,
    input logic [7:0] t,
    input logic d,
    input logic hi,
    input logic lo
  );
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_ZERO_LO)
      v = z[7:0];
    else if (a == REG_ZERO_HI)
      v = z[15:8];
    else if (a == REG_THRESH)
      v = t;
    else if (a == REG_DIR)
      v = {d, 7'h00};
    else if (a == REG_FLAGS)
      v = {hi, lo, 6'h00};
    return v;
  endfunction : reg_value

  // two-stage synchronisers; third stage only for edge finding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {mosi_s1, mosi_s2} <= 2'h0;
      {ph_s1, ph_s2, ph_s3} <= 3'h0;
    end
    else
    begin
      sclk_s1 <= spi.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= spi.cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      mosi_s1 <= spi.mosi;
      mosi_s2 <= mosi_s1;
      ph_s1 <= phase_zero;
      ph_s2 <= ph_s1;
      ph_s3 <= ph_s2;
    end
  end

  assign rise = sclk_s2 && !sclk_s3;
  assign fall = !sclk_s2 && sclk_s3;
  assign cs_fall = !cs_s2 && cs_s3;
  assign cs_rise = cs_s2 && !cs_s3;

  // frame engine and register store
  always_comb
  begin
    mode3_d = mode3_q;
    first_d = first_q;
    tx_d = tx_q;
    rx_d = rx_q;
    cnt_d = cnt_q;
    oe_n_d = oe_n_q;
    reply_d = reply_q;
    raddr_d = raddr_q;
    busy_d = busy_q;
    wcnt_d = wcnt_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    zero_d = zero_q;
    thr_d = thr_q;
    dir_d = dir_q;
    if (cs_fall)
    begin
      mode3_d = sclk_s2;
      first_d = 1'b1;
      cnt_d = 5'h00;
      rx_d = 16'h0000;
      oe_n_d = 1'b0;
      if (reply_q)
        tx_d = {reg_value(raddr_q, zero_q, thr_q, dir_q, field_high_flag, field_low_flag), 8'h00};
      else
        tx_d = {angle_out, {(FRAME_BITS - ANGLE_BITS){1'b0}}};
    end
    else if (!cs_s2)
    begin
      if (rise)
      begin
        rx_d = {rx_q[14:0], mosi_s2};
        if (cnt_q != 5'(FRAME_BITS))
          cnt_d = cnt_q + 5'h01;
        first_d = 1'b0;
      end
      if (fall)
      begin
        // mode 3 opens on a falling edge that launches bit 15 itself
        if (!(mode3_q && first_q))
          tx_d = {tx_q[14:0], 1'b0};
        first_d = 1'b0;
      end
    end
    if (cs_rise)
    begin
      oe_n_d = 1'b1;
      reply_d = 1'b0;
      // short frames are partial angle reads and carry no command
      if (cnt_q == 5'(FRAME_BITS))
      begin
        if (rx_q[15:13] == CMD_READ)
        begin
          reply_d = 1'b1;
          raddr_d = rx_q[12:8];
        end
        else if (rx_q[15:13] == CMD_WRITE)
        begin
          reply_d = 1'b1;
          raddr_d = rx_q[12:8];
          if (!busy_q)
          begin
            busy_d = 1'b1;
            wcnt_d = WC_W'(NVM_WAIT_CYC - 1);
            waddr_d = rx_q[12:8];
            wdata_d = rx_q[7:0];
          end
        end
      end
    end
    // until the wait ends, readback shows the previous value
    if (busy_q)
    begin
      if (wcnt_q == '0)
      begin
        busy_d = 1'b0;
        if (waddr_q == REG_ZERO_LO)
          zero_d[7:0] = wdata_q;
        else if (waddr_q == REG_ZERO_HI)
          zero_d[15:8] = wdata_q;
        else if (waddr_q == REG_THRESH)
          thr_d = wdata_q;
        else if (waddr_q == REG_DIR)
          dir_d = wdata_q[DIR_BIT];
      end
      else
        wcnt_d = wcnt_q - WC_W'(1);
    end
  end

  // time-to-digital front end and outputs
  always_comb
  begin
    ref_d = (ref_q == 7'(SAMPLE_CYC - 1)) ? 7'h00 : ref_q + 7'h01;
    acc_d = (ref_q == 7'(SAMPLE_CYC - 1)) ? 16'h0000 : acc_q + TDC_STEP;
    sv_d = ph_s2 && !ph_s3;
    samp_d = sv_d ? acc_q : samp_q;
    // negate for the other sense, then add the zero register
    turned = (dir_q ? 16'(-filt) : filt) + zero_q;
    ang_d = turned[15:16-ANGLE_BITS];
    low_d = field_strength < {thr_q[LOW_THR_LSB +: 3], 5'h00};
    high_d = field_strength > {thr_q[HIGH_THR_LSB +: 3], 5'h00};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode3_q <= 1'b0;
      first_q <= 1'b0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      cnt_q <= 5'h00;
      oe_n_q <= 1'b1;
      reply_q <= 1'b0;
      raddr_q <= 5'h00;
      busy_q <= 1'b0;
      wcnt_q <= '0;
      waddr_q <= 5'h00;
      wdata_q <= 8'h00;
      zero_q <= 16'h0000;
      thr_q <= THRESH_RST;
      dir_q <= 1'b0;
      ref_q <= 7'h00;
      acc_q <= 16'h0000;
      samp_q <= 16'h0000;
      sv_q <= 1'b0;
      field_low_flag <= 1'b0;
      field_high_flag <= 1'b0;
      angle_out <= '0;
    end
    else
    begin
      mode3_q <= mode3_d;
      first_q <= first_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      cnt_q <= cnt_d;
      oe_n_q <= oe_n_d;
      reply_q <= reply_d;
      raddr_q <= raddr_d;
      busy_q <= busy_d;
      wcnt_q <= wcnt_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      zero_q <= zero_d;
      thr_q <= thr_d;
      dir_q <= dir_d;
      ref_q <= ref_d;
      acc_q <= acc_d;
      samp_q <= samp_d;
      sv_q <= sv_d;
      field_low_flag <= low_d;
      field_high_flag <= high_d;
      angle_out <= ang_d;
    end
  end

  angle_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_valid(sv_q),
    .sample(samp_q),
    .angle(filt)
  );

  assign spi.miso_o = tx_q[15];
  assign spi.miso_oe_n = oe_n_q;
  assign spi.miso_pd = oe_n_q;
endmodule : sensor_end

// [design/angle_spi_pkg.sv]
// Purpose: shared constants for the angle sensor serial port and its host
// Assumes: aclk at 100 MHz on both ends
// Notes: register numbers are the sensor's own 5-bit addresses
//
// Overview of operation
// - sensor serves mode 0 and mode 3
// - mode picked from clock level at select
// - serial clock up to 25 MHz, no floor
// - host sends exactly sixteen-bit commands
// - launch on falling, sample on rising
// - 150 ns idle between angle reads
// - 750 ns idle around register readout
// - 20 ms wait after a write
// - low flag when field under low threshold
// - high flag when field over high threshold
// - pull-down on data-out while not driving
// - new angle sample at 1 MHz, open loop
// - sample is zero crossing to reference time
// - filter (1+2ts)/(1+ts)^2, t = 0.38/fc
// - filter adds no steady-state lag
// - default angle rises clockwise
// - direction and zero are programmable
// - read: code 010 plus address, reply value
// - write: code 100, address, value, echo
// - angle read is sixteen clock pulses
// - unused angle bits are sent as zero
package angle_spi_pkg;
  localparam int CLK_NS = 10;
  localparam int FRAME_BITS = 16;
  localparam int ANGLE_BITS = 8;
  localparam int FIELD_W = 8;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  // sensor register numbers and reset values
  localparam logic [4:0] REG_ZERO_LO = 5'h00;
  localparam logic [4:0] REG_ZERO_HI = 5'h01;
  localparam logic [4:0] REG_THRESH = 5'h06;
  localparam logic [4:0] REG_DIR = 5'h09;
  localparam logic [4:0] REG_FLAGS = 5'h1B;
  localparam logic [7:0] THRESH_RST = 8'h1C;
  localparam int LOW_THR_LSB = 5;
  localparam int HIGH_THR_LSB = 2;
  localparam int DIR_BIT = 7;
  // link timing, figures in ns, ms or MHz, counts derived
  localparam int ANGLE_GAP_NS = 150;
  localparam int REG_GAP_NS = 750;
  localparam int NVM_WAIT_MS = 20;
  localparam int ANGLE_GAP_CYC = (ANGLE_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int REG_GAP_CYC = (REG_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int NVM_WAIT_CYC = NVM_WAIT_MS * 1000000 / CLK_NS;
  localparam int MAX_SCLK_MHZ = 25;
  localparam int MIN_HALF = 1000 / (2 * MAX_SCLK_MHZ * CLK_NS);
  // front end: 1 MHz reference, angle filter constants
  localparam int SAMPLE_NS = 1000;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam logic [15:0] TDC_STEP = 16'(65536 / SAMPLE_CYC);
  localparam int FRAC_W = 24;
  localparam int SHIFT_P = 11;
  // host register map, byte offsets
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] HOST_TX = 4'h0;
  localparam logic [3:0] HOST_RX = 4'h4;
  localparam logic [3:0] HOST_STATUS = 4'h8;
  localparam logic [3:0] HOST_CONFIG = 4'hC;
  localparam logic [7:0] HALF_RST = 8'h08;
  localparam int MODE3_BIT = 8;
endpackage : angle_spi_pkg

// [design/angle_spi_if.sv]
// Purpose: four-wire serial link between sensor and host
// Assumes: one sensor per select line
// Notes: resolves the data-out wire from enable and pull-down
`timescale 1ns/1ps
interface angle_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso_pd;
  wire logic miso;
  // weak pull-down wins only while the sensor floats the line;
  // an unpulled float shows the inverse so a missed drive is caught
  assign miso = !miso_oe_n ? miso_o : (miso_pd ? 1'b0 : !miso_o);
  modport sensor (
    input sclk, cs_n, mosi,
    output miso_o, miso_oe_n, miso_pd
  );
  modport host (
    output sclk, cs_n, mosi,
    input miso
  );
endinterface : angle_spi_if

// [design/angle_filter.sv]
// Purpose: conditioning filter for raw angle samples
// Assumes: one sample pulse per microsecond
// Notes: critically damped tracking loop, wraps modulo one turn
`timescale 1ns/1ps
module angle_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw samples
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  // filtered angle
  output logic [15:0] angle
);
  import angle_spi_pkg::*;
  localparam int ACC_W = 16 + FRAC_W;
  logic [ACC_W-1:0] pos_q, pos_d;
  logic [ACC_W-1:0] vel_q, vel_d;
  logic signed [15:0] err;
  logic [ACC_W-1:0] err_x;

  // loop y' = v + 2e/t, v' = e/t^2 gives (1+2ts)/(1+ts)^2
  always_comb
  begin
    err = signed'(sample - pos_q[ACC_W-1:FRAC_W]);
    err_x = ACC_W'(signed'(err));
    pos_d = pos_q;
    vel_d = vel_q;
    if (sample_valid)
    begin
      vel_d = vel_q + err_x;
      pos_d = pos_q + vel_q + (err_x << (FRAC_W - SHIFT_P));
    end
  end

  // velocity term tracks a ramp with zero error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_q <= '0;
      vel_q <= '0;
    end
    else
    begin
      pos_q <= pos_d;
      vel_q <= vel_d;
    end
  end

  assign angle = pos_q[ACC_W-1:FRAC_W];
endmodule : angle_filter

// [design/host_end.sv]
// Purpose: serial host for the angle sensor, run from AXI4-Lite registers
// Assumes: one frame at a time, software orders the frames
// Notes: idle gaps after each frame are enforced here
`timescale 1ns/1ps
module host_end #(
  parameter int NVM_WAIT_CYC = angle_spi_pkg::NVM_WAIT_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [angle_spi_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [angle_spi_pkg::AXI_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // serial link
  angle_spi_if.host spi
);
  import angle_spi_pkg::*;
  localparam int GW = $clog2(NVM_WAIT_CYC + 1);
  typedef enum logic [4:0] {
    IDLE = 5'h01, LEAD = 5'h02, SHIFT = 5'h04, TRAIL = 5'h08, GAP = 5'h10
  } link_t;
  link_t st_q, st_d;
  logic aw_q, aw_d, w_q, w_d, go_q, go_d, mode3_q, mode3_d, busy;
  logic [3:0] wa_q, wa_d;
  logic [31:0] wd_q, wd_d;
  logic [15:0] txw_q, txw_d, rxw_q, rxw_d, txs_q, txs_d, rxs_q, rxs_d;
  logic [7:0] div_q, div_d, half_q, half_d;
  logic [4:0] h_q, h_d;
  logic [GW-1:0] gap_q, gap_d;
  logic rdp_q, rdp_d, sclk_q, sclk_d, cs_q, cs_d, mosi_q, mosi_d, miso_s1, miso_s2;
  logic awr_d, wr_d, bv_d, arr_d, rv_d;
  logic [1:0] br_d, rr_d;
  logic [31:0] rd_d;

  assign busy = (st_q != IDLE) || go_q;

  // register slave: address and data accepted in either order
  always_comb
  begin
    {aw_d, wa_d, w_d, wd_d, go_d} = {aw_q, wa_q, w_q, wd_q, 1'b0};
    {txw_d, div_d, mode3_d, bv_d, br_d} = {txw_q, div_q, mode3_q, bvalid, bresp};
    {rv_d, rd_d, rr_d} = {rvalid, rdata, rresp};
    if (awvalid && awready)
      {aw_d, wa_d} = {1'b1, awaddr};
    if (wvalid && wready)
      {w_d, wd_d} = {1'b1, wdata};
    if (bvalid && bready)
      bv_d = 1'b0;
    if (aw_q && w_q && !bvalid)
    begin
      {aw_d, w_d, bv_d, br_d} = {2'b00, 1'b1, 2'b00};
      if (wa_q == HOST_TX && !busy)
        {txw_d, go_d} = {wd_q[15:0], 1'b1};
      else if (wa_q == HOST_CONFIG)
      begin
        if (wstrb[0])
          div_d = (wd_q[7:0] < 8'(MIN_HALF)) ? 8'(MIN_HALF) : wd_q[7:0];
        if (wstrb[1])
          mode3_d = wd_q[MODE3_BIT];
      end
      else
        br_d = 2'b10; // busy, read-only or unmapped
    end
    if (rvalid && rready)
      rv_d = 1'b0;
    if (arvalid && arready)
    begin
      {rv_d, rr_d, rd_d} = {1'b1, 2'b00, 32'h0000_0000};
      if (araddr == HOST_TX)
        rd_d[15:0] = txw_q;
      else if (araddr == HOST_RX)
        rd_d[15:0] = rxw_q;
      else if (araddr == HOST_STATUS)
        rd_d[0] = busy;
      else if (araddr == HOST_CONFIG)
        rd_d[MODE3_BIT:0] = {mode3_q, div_q};
      else
        rr_d = 2'b10;
    end
    awr_d = !aw_d && !bv_d;
    wr_d = !w_d && !bv_d;
    arr_d = !rv_d;
  end

  // link sequencer: half-period ticks from div
  always_comb
  begin
    st_d = st_q;
    {half_d, h_d, gap_d, rdp_d} = {half_q, h_q, gap_q, rdp_q};
    {sclk_d, cs_d, mosi_d, txs_d, rxs_d, rxw_d} = {sclk_q, cs_q, mosi_q, txs_q, rxs_q, rxw_q};
    if (half_q != 8'h00)
      half_d = half_q - 8'h01;
    case (st_q)
      IDLE:
      begin
        sclk_d = mode3_q;
        if (go_q)
        begin
          {cs_d, txs_d, mosi_d} = {1'b0, txw_q, txw_q[15]};
          half_d = div_q - 8'h01;
          st_d = LEAD;
        end
      end
      LEAD:
        if (half_q == 8'h00)
        begin
          {sclk_d, h_d, half_d} = {1'b0, 5'h00, div_q - 8'h01};
          st_d = SHIFT;
        end
      SHIFT:
        if (half_q == 8'h00)
        begin
          {half_d, h_d} = {div_q - 8'h01, h_q + 5'h01};
          if (h_q == 5'h1F)
          begin
            sclk_d = mode3_q;
            st_d = TRAIL;
          end
          else if (!h_q[0])
            {sclk_d, rxs_d} = {1'b1, rxs_q[14:0], miso_s2};
          else
            {sclk_d, mosi_d, txs_d} = {1'b0, txs_q[14], txs_q[14:0], 1'b0};
        end
      TRAIL:
        if (half_q == 8'h00)
        begin
          {cs_d, rxw_d} = {1'b1, rxs_q};
          st_d = GAP;
          rdp_d = (txw_q[15:13] == CMD_READ);
          if (txw_q[15:13] == CMD_WRITE)
            gap_d = GW'(NVM_WAIT_CYC - 1);
          else if (txw_q[15:13] == CMD_READ || rdp_q)
            gap_d = GW'(REG_GAP_CYC - 1);
          else
            gap_d = GW'(ANGLE_GAP_CYC - 1);
        end
      GAP:
        if (gap_q == '0)
          st_d = IDLE;
        else
          gap_d = gap_q - GW'(1);
      default:
        st_d = IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_q, wa_q, w_q, wd_q, go_q, txw_q, div_q, mode3_q} <= {1'b0, 4'h0, 1'b0, 32'h0, 1'b0, 16'h0, HALF_RST, 1'b0};
      {awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp} <= {3'b110, 2'b00, 2'b10, 32'h0, 2'b00};
      st_q <= IDLE;
      {half_q, h_q, gap_q, rdp_q} <= {8'h00, 5'h00, {GW{1'b0}}, 1'b0};
      {sclk_q, cs_q, mosi_q, txs_q, rxs_q, rxw_q, miso_s1, miso_s2} <= {3'b010, 48'h0, 2'b00};
    end
    else
    begin
      {aw_q, wa_q, w_q, wd_q, go_q, txw_q, div_q, mode3_q} <= {aw_d, wa_d, w_d, wd_d, go_d, txw_d, div_d, mode3_d};
      {awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp} <= {awr_d, wr_d, bv_d, br_d, arr_d, rv_d, rd_d, rr_d};
      st_q <= st_d;
      {half_q, h_q, gap_q, rdp_q} <= {half_d, h_d, gap_d, rdp_d};
      {sclk_q, cs_q, mosi_q, txs_q, rxs_q, rxw_q} <= {sclk_d, cs_d, mosi_d, txs_d, rxs_d, rxw_d};
      miso_s1 <= spi.miso;
      miso_s2 <= miso_s1;
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_q;
  assign spi.mosi = mosi_q;
endmodule : host_end

// [tb/angle_link_sva.sv]
// Purpose: link checks between the sensor and host ends
// Assumes: host half period left at its reset value of 8 cycles
// Notes: sees only the wires of the joining interface
`timescale 1ns/1ps
module angle_link_sva #(
  // bench's shortened nonvolatile wait, at most 255 cycles
  parameter int NVM_GAP = 200
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic miso_pd,
  input wire logic miso
);
  import angle_spi_pkg::*;
  logic sclk_q;
  logic sclk_d;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic [4:0] rise_q;
  logic [4:0] rise_d;
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [2:0] kind_q;
  logic [2:0] kind_d;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // idle and edge counts; the idle count saturates so a long idle never wraps
  always_comb
  begin
    sclk_d = sclk;
    gap_d = !cs_n ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
    rise_d = cs_n ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};
    // host command bits as the sensor samples them
    cmd_d = (!cs_n && sclk && !sclk_q) ? {cmd_q[14:0], mosi} : cmd_q;
    kind_d = kind_q;
    // first idle sample after a frame classifies it: write, readout, read
    if (cs_n && gap_q == 8'h00)
      kind_d = {cmd_q[15:13] == CMD_WRITE, kind_q[0], cmd_q[15:13] == CMD_READ};
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_q <= 1'b0;
      gap_q <= 8'hFF;
      rise_q <= 5'h00;
      cmd_q <= 16'h0000;
      kind_q <= 3'h0;
    end
    else
    begin
      sclk_q <= sclk_d;
      gap_q <= gap_d;
      rise_q <= rise_d;
      cmd_q <= cmd_d;
      kind_q <= kind_d;
    end
  end
  select_drive_a: assert property ($fell(cs_n) |-> ##[1:6] !miso_oe_n)
    else $error("data-out not driven after select fell");
  idle_float_a: assert property (cs_n [*5] |-> miso_oe_n)
    else $error("data-out driven while deselected");
  float_pulldown_a: assert property (miso_oe_n |-> miso_pd)
    else $error("pull-down off while floating");
  float_low_a: assert property (miso_oe_n |-> miso == 1'b0)
    else $error("floating data-out not pulled low");
  mosi_launch_a: assert property ($changed(mosi) && !cs_n && !$fell(cs_n) |-> !sclk)
    else $error("host data moved while clock high");
  miso_hold_a: assert property ($rose(sclk) && !cs_n |=> $stable(miso_o) [*3])
    else $error("sensor data moved at sampling edge");
  // a half period below eight cycles would outrun the sensor synchroniser
  half_period_a: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  angle_gap_a: assert property ($fell(cs_n) |-> gap_q >= 8'h0F)
    else $error("select idle gap too short");
  sixteen_rise_a: assert property ($rose(cs_n) |-> rise_q == 5'h10)
    else $error("frame without sixteen rising edges");
  reg_gap_a: assert property ($fell(cs_n) && kind_q[1:0] != 2'b00 |-> gap_q >= 8'(REG_GAP_CYC))
    else $error("idle gap around register readout too short");
  nvm_gap_a: assert property ($fell(cs_n) && kind_q[2] |-> gap_q >= 8'(NVM_GAP))
    else $error("readout too soon after a register write");
endmodule : angle_link_sva

// [tb/angle_sensor_spi_port_tb.sv]
// Purpose: both ends joined, driven over the host registers
// Assumes: nonvolatile wait shortened to 200 cycles on both ends
// Notes: software polls busy before each new frame
`timescale 1ns/1ps
module angle_sensor_spi_port_tb;
  import angle_spi_pkg::*;
  logic aclk;
  logic aresetn;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic phase_zero;
  logic [6:0] pz_cnt;
  logic [7:0] field_strength, angle_out;
  logic field_low_flag, field_high_flag;
  int err_count;
  int comparisons;
  angle_spi_if i_angle_spi_if ();
  sensor_end #(.NVM_WAIT_CYC(200)) i_sensor_end (.aclk(aclk), .aresetn(aresetn), .spi(i_angle_spi_if.sensor),
    .phase_zero(phase_zero), .field_strength(field_strength), .field_low_flag(field_low_flag),
    .field_high_flag(field_high_flag), .angle_out(angle_out));
  host_end #(.NVM_WAIT_CYC(200)) i_host_end (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .spi(i_angle_spi_if.host));
  angle_link_sva i_angle_link_sva (.aclk(aclk), .aresetn(aresetn), .sclk(i_angle_spi_if.sclk),
    .cs_n(i_angle_spi_if.cs_n), .mosi(i_angle_spi_if.mosi), .miso_o(i_angle_spi_if.miso_o),
    .miso_oe_n(i_angle_spi_if.miso_oe_n), .miso_pd(i_angle_spi_if.miso_pd), .miso(i_angle_spi_if.miso));
  always #(CLK_NS / 2) aclk = ~aclk;
  // steady zero crossing each microsecond keeps the angle nearly still
  always @(posedge aclk)
  begin
    pz_cnt <= (pz_cnt == 7'h63) ? 7'h00 : pz_cnt + 7'h01;
    phase_zero <= (pz_cnt < 7'h28);
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      done = bvalid;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      done = rvalid;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // busy covers the frame and the gap the host keeps after it
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h1;
    while (d[0]) axi_rd(HOST_STATUS, d, r);
  endtask : wait_idle
  task automatic frame(input logic [15:0] w, output logic [15:0] rx);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(HOST_TX, {16'h0000, w}, r);
    chk("frame start", {30'h0, r}, 32'h0);
    wait_idle();
    axi_rd(HOST_RX, d, r);
    rx = d[15:0];
  endtask : frame
  task automatic t_idle();
    logic [31:0] d;
    logic [1:0] r;
    chk("select idle", {31'h0, i_angle_spi_if.cs_n}, 32'h1);
    axi_rd(HOST_CONFIG, d, r);
    chk("config reset", d, {24'h0, HALF_RST});
    axi_rd(4'h2, d, r);
    chk("unmapped read", {r, d[29:0]}, 32'h80000000);
    axi_wr(HOST_STATUS, 32'h1, r);
    chk("status write", {30'h0, r}, 32'h2);
  endtask : t_idle
  task automatic t_reg_read(input logic [7:0] exp);
    logic [15:0] rx;
    frame({CMD_READ, REG_THRESH, 8'h00}, rx);
    frame(16'h0000, rx);
    chk("threshold reply", {16'h0, rx}, {16'h0, exp, 8'h00});
  endtask : t_reg_read
  task automatic t_write(input logic [4:0] a, input logic [7:0] v);
    logic [15:0] rx;
    logic [1:0] r;
    axi_wr(HOST_TX, {16'h0, CMD_WRITE, a, v}, r);
    axi_wr(HOST_TX, 32'h0, r);
    chk("tx while busy", {30'h0, r}, 32'h2);
    wait_idle();
    frame(16'h0000, rx);
    chk("write echo", {16'h0, rx}, {16'h0, v, 8'h00});
  endtask : t_write
  // filter drift between the two looks stays under one step
  task automatic t_turn();
    logic [7:0] a0;
    logic [7:0] df;
    a0 = angle_out;
    t_write(REG_ZERO_HI, 8'h5A);
    df = angle_out - a0 - 8'h59;
    chk("zero shift", {31'h0, df <= 8'h02}, 32'h1);
    a0 = angle_out;
    t_write(REG_DIR, 8'h80);
    df = angle_out + a0 - 8'hB2;
    chk("reverse sense", {31'h0, df <= 8'h03}, 32'h1);
  endtask : t_turn
  task automatic t_angle();
    logic [15:0] rx;
    logic [7:0] a0;
    logic [7:0] df;
    a0 = angle_out;
    frame(16'h0000, rx);
    df = rx[15:8] - a0 + 8'h01;
    chk("angle pad", {24'h0, rx[7:0]}, 32'h0);
    chk("angle value", {31'h0, df <= 8'h02}, 32'h1);
  endtask : t_angle
  task automatic t_flags();
    logic [15:0] rx;
    field_strength <= 8'hFF;
    frame({CMD_READ, REG_FLAGS, 8'h00}, rx);
    chk("high flag", {30'h0, field_high_flag, field_low_flag}, 32'h2);
    frame(16'h0000, rx);
    chk("flag register", {16'h0, rx}, 32'h8000);
    // low threshold raised to 0x80, high kept at 0xE0
    t_write(REG_THRESH, 8'h9C);
    field_strength <= 8'h10;
    repeat (4) @(posedge aclk);
    chk("low flag", {30'h0, field_high_flag, field_low_flag}, 32'h1);
    field_strength <= 8'h90;
    repeat (4) @(posedge aclk);
    chk("no flag", {30'h0, field_high_flag, field_low_flag}, 32'h0);
  endtask : t_flags
  task automatic t_mode3();
    logic [1:0] r;
    axi_wr(HOST_CONFIG, 32'h108, r);
    repeat (4) @(posedge aclk);
    chk("mode 3 idle clock", {31'h0, i_angle_spi_if.sclk}, 32'h1);
    t_reg_read(8'h9C);
    t_angle();
    axi_wr(HOST_CONFIG, 32'h8, r);
  endtask : t_mode3
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, phase_zero} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = {4'h0, 4'h0, 4'hF, 32'h0};
    pz_cnt = 7'h00;
    field_strength = 8'h40;
    err_count = 0;
    comparisons = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_idle();
    t_reg_read(THRESH_RST);
    t_turn();
    t_angle();
    t_flags();
    t_mode3();
    t_angle();
    report_and_stop();
  end
  // hang guard, well beyond the few thousand cycles the run needs
  initial
  begin
    repeat (60000) @(posedge aclk);
    err_count++;
    report_and_stop();
  end
endmodule : angle_sensor_spi_port_tb
